// ---- src/sdd_pkg.sv ----
// constants, types and glyph font for the two-digit segment display controller
// Summary of operation
// - select 0000 shows upper byte, 0001 lower
// - any byte 00 to FF shown as hex
// - shown content held until next command
// - bad select sets fault, display untouched
// - most recent command's content is shown
// - priority: error, user, analog, removable memory
// - user content kept and restored after error
// - each pattern bit lights one segment
// - zero pattern blanks user display only
// - pattern command leaves fault flag alone
package sdd_pkg;

	// digit select codes on the select word
	localparam logic [15:0] SDD_SEL_UPPER = 16'h0000;
	localparam logic [15:0] SDD_SEL_LOWER = 16'h0001;

	// field layout of a 16-bit segment word
	localparam int SDD_LEFT_HI = 15;
	localparam int SDD_LEFT_LO = 8;
	localparam int SDD_RIGHT_HI = 7;
	localparam int SDD_RIGHT_LO = 0;
	localparam int SDD_DP_BIT = 7;

	// reset values and blank pattern
	localparam logic [15:0] SDD_SEG_BLANK = 16'h0000;
	localparam logic [7:0] SDD_BYTE_RST = 8'h00;
	localparam logic SDD_DP_OFF = 1'b0;

	// glyphs, bit0 = segment a through bit6 = segment g
	localparam logic [6:0] SDD_GLYPH_0 = 7'h3F;
	localparam logic [6:0] SDD_GLYPH_1 = 7'h06;
	localparam logic [6:0] SDD_GLYPH_2 = 7'h5B;
	localparam logic [6:0] SDD_GLYPH_3 = 7'h4F;
	localparam logic [6:0] SDD_GLYPH_4 = 7'h66;
	localparam logic [6:0] SDD_GLYPH_5 = 7'h6D;
	localparam logic [6:0] SDD_GLYPH_6 = 7'h7D;
	localparam logic [6:0] SDD_GLYPH_7 = 7'h07;
	localparam logic [6:0] SDD_GLYPH_8 = 7'h7F;
	localparam logic [6:0] SDD_GLYPH_9 = 7'h6F;
	localparam logic [6:0] SDD_GLYPH_A = 7'h77;
	localparam logic [6:0] SDD_GLYPH_B = 7'h7C;
	localparam logic [6:0] SDD_GLYPH_C = 7'h39;
	localparam logic [6:0] SDD_GLYPH_D = 7'h5E;
	localparam logic [6:0] SDD_GLYPH_E = 7'h79;
	localparam logic [6:0] SDD_GLYPH_F = 7'h71;

	// source currently driving the display
	typedef enum logic [2:0] {
		SDD_SRC_NONE = 3'b000,
		SDD_SRC_ERROR = 3'b001,
		SDD_SRC_USER = 3'b010,
		SDD_SRC_ANALOG = 3'b011,
		SDD_SRC_MEMORY = 3'b100
	} sdd_src_type;

	// whole state of the controller
	typedef struct packed {
		logic [15:0] user_seg;
		logic user_on;
		logic [7:0] shown_byte;
		logic fault;
		logic [15:0] disp;
		sdd_src_type src;
	} sdd_state_type;

endpackage : sdd_pkg

// ---- src/sdd_hex_font.sv ----
// nibble to seven-segment glyph decoder
`timescale 1ns/1ps
module sdd_hex_font
	import sdd_pkg::*;
(
	// nibble in
	input wire logic [3:0] nibble,
	// glyph out, a in bit 0
	output logic [6:0] glyph
);

	// fixed hex font, every code has a glyph
	always_comb begin
		unique case (nibble)
			4'h0: glyph = SDD_GLYPH_0;
			4'h1: glyph = SDD_GLYPH_1;
			4'h2: glyph = SDD_GLYPH_2;
			4'h3: glyph = SDD_GLYPH_3;
			4'h4: glyph = SDD_GLYPH_4;
			4'h5: glyph = SDD_GLYPH_5;
			4'h6: glyph = SDD_GLYPH_6;
			4'h7: glyph = SDD_GLYPH_7;
			4'h8: glyph = SDD_GLYPH_8;
			4'h9: glyph = SDD_GLYPH_9;
			4'hA: glyph = SDD_GLYPH_A;
			4'hB: glyph = SDD_GLYPH_B;
			4'hC: glyph = SDD_GLYPH_C;
			4'hD: glyph = SDD_GLYPH_D;
			4'hE: glyph = SDD_GLYPH_E;
			4'hF: glyph = SDD_GLYPH_F;
		endcase
	end

endmodule : sdd_hex_font

// ---- src/sdd_prio_sel.sv ----
// fixed-priority choice of the display source
`timescale 1ns/1ps
module sdd_prio_sel
	import sdd_pkg::*;
(
	// system error message
	input wire logic err_on,
	input wire logic [15:0] err_seg,
	// user display content
	input wire logic user_on,
	input wire logic [15:0] user_seg,
	// analog adjustment display
	input wire logic ana_on,
	input wire logic [15:0] ana_seg,
	// removable memory processing display
	input wire logic mem_on,
	input wire logic [15:0] mem_seg,
	// chosen source and pattern
	output sdd_src_type src,
	output logic [15:0] seg
);

	// highest active source wins
	always_comb begin
		if (err_on) begin
			src = SDD_SRC_ERROR;
			seg = err_seg;
		end else if (user_on) begin
			src = SDD_SRC_USER;
			seg = user_seg;
		end else if (ana_on) begin
			src = SDD_SRC_ANALOG;
			seg = ana_seg;
		end else if (mem_on) begin
			src = SDD_SRC_MEMORY;
			seg = mem_seg;
		end else begin
			src = SDD_SRC_NONE;
			seg = SDD_SEG_BLANK;
		end
	end

endmodule : sdd_prio_sel

// ---- src/sdd_ctrl.sv ----
// two-digit segment display controller top
`timescale 1ns/1ps
module sdd_ctrl
	import sdd_pkg::*;
(
	// clock and synchronous reset
	input wire logic clk,
	input wire logic srst,
	// hex digit show command
	input wire logic hex_digit_show_cmd,
	input wire logic [15:0] src_word,
	input wire logic [15:0] sel_word,
	// segment pattern command
	input wire logic segment_pattern_cmd,
	input wire logic [15:0] pattern_word,
	// system error message display
	input wire logic sys_err_on,
	input wire logic [15:0] sys_err_seg,
	// analog adjustment display
	input wire logic analog_on,
	input wire logic [15:0] analog_seg,
	// removable memory processing display
	input wire logic memory_on,
	input wire logic [15:0] memory_seg,
	// segment drive, upper byte left digit
	output logic [15:0] seg_out,
	// source now shown
	output sdd_src_type disp_src,
	// fault flag of the last digit command issued without a pattern command
	output logic fault_flag,
	// user content stored
	output logic user_display_on
);

	// registered state and its next value
	sdd_state_type state_r;
	sdd_state_type state_nxt;

	// select word decode
	logic sel_upper;
	logic sel_lower;
	logic sel_ok;
	// byte picked from the source word
	logic [7:0] pick_byte;
	// glyphs of the picked byte
	logic [6:0] glyph_hi;
	logic [6:0] glyph_lo;
	// hex command result as segment word
	logic [15:0] hex_seg;
	// user content after this cycle's commands
	logic [15:0] user_seg_new;
	logic user_on_new;
	// priority result
	sdd_src_type prio_src;
	logic [15:0] prio_seg;

	// decode the digit select
	always_comb begin
		sel_upper = (sel_word == SDD_SEL_UPPER);
		sel_lower = (sel_word == SDD_SEL_LOWER);
		sel_ok = sel_upper | sel_lower;
	end

	// pick upper or lower byte of the source
	always_comb begin
		if (sel_upper) begin
			pick_byte = src_word[SDD_LEFT_HI:SDD_LEFT_LO];
		end else begin
			pick_byte = src_word[SDD_RIGHT_HI:SDD_RIGHT_LO];
		end
	end

	// font for the left digit
	sdd_hex_font u_font_hi (
		.nibble(pick_byte[7:4]),
		.glyph(glyph_hi)
	);

	// font for the right digit
	sdd_hex_font u_font_lo (
		.nibble(pick_byte[3:0]),
		.glyph(glyph_lo)
	);

	// two glyphs, decimal points dark
	always_comb begin
		hex_seg = {SDD_DP_OFF, glyph_hi, SDD_DP_OFF, glyph_lo};
	end

	// user content update, pattern wins over a digit command in the same cycle
	always_comb begin
		user_seg_new = state_r.user_seg;
		user_on_new = state_r.user_on;
		if (segment_pattern_cmd) begin
			// raw pattern, one bit per segment
			user_seg_new = pattern_word;
			// zero pattern erases user content only
			user_on_new = (pattern_word != SDD_SEG_BLANK);
		end else if (hex_digit_show_cmd && sel_ok) begin
			// latest digit command replaces content
			user_seg_new = hex_seg;
			user_on_new = 1'b1;
		end
		// otherwise content is held
	end

	// choose which source reaches the segments
	sdd_prio_sel u_prio (
		.err_on(sys_err_on),
		.err_seg(sys_err_seg),
		.user_on(user_on_new),
		.user_seg(user_seg_new),
		.ana_on(analog_on),
		.ana_seg(analog_seg),
		.mem_on(memory_on),
		.mem_seg(memory_seg),
		.src(prio_src),
		.seg(prio_seg)
	);

	// next state
	always_comb begin
		state_nxt = state_r;
		state_nxt.user_seg = user_seg_new;
		state_nxt.user_on = user_on_new;
		state_nxt.disp = prio_seg;
		state_nxt.src = prio_src;
		if (hex_digit_show_cmd && !segment_pattern_cmd) begin
			// fault follows the select of each digit command not paired with a pattern command
			state_nxt.fault = !sel_ok;
			if (sel_ok) begin
				state_nxt.shown_byte = pick_byte;
			end
		end
		// pattern command never touches the fault
	end

	// register the state
	always_ff @(posedge clk) begin
		if (srst) begin
			state_r.user_seg <= SDD_SEG_BLANK;
			state_r.user_on <= 1'b0;
			state_r.shown_byte <= SDD_BYTE_RST;
			state_r.fault <= 1'b0;
			state_r.disp <= SDD_SEG_BLANK;
			state_r.src <= SDD_SRC_NONE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// outputs straight from the state
	assign seg_out = state_r.disp;
	assign disp_src = state_r.src;
	assign fault_flag = state_r.fault;
	assign user_display_on = state_r.user_on;

	// upper select shows the upper byte
	property p_sel_upper;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && sel_word == SDD_SEL_UPPER
			|=> state_r.shown_byte == $past(src_word[SDD_LEFT_HI:SDD_LEFT_LO]);
	endproperty
	a_sel_upper: assert property (p_sel_upper) else $error("upper byte not shown");

	// lower select shows the lower byte
	property p_sel_lower;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && sel_word == SDD_SEL_LOWER
			|=> state_r.shown_byte == $past(src_word[SDD_RIGHT_HI:SDD_RIGHT_LO]);
	endproperty
	a_sel_lower: assert property (p_sel_lower) else $error("lower byte not shown");

	// valid digit command stores both glyphs with dark points
	property p_hex_glyphs;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && sel_ok
			|=> state_r.user_on && state_r.user_seg == $past(hex_seg)
			&& !state_r.user_seg[SDD_DP_BIT]
			&& state_r.user_seg[SDD_LEFT_HI-1:SDD_LEFT_LO] != SDD_SEG_BLANK[SDD_RIGHT_HI-1:SDD_RIGHT_LO];
	endproperty
	a_hex_glyphs: assert property (p_hex_glyphs) else $error("hex glyphs wrong");

	// no command keeps user content for two cycles
	property p_hold;
		@(posedge clk) disable iff (srst)
		!hex_digit_show_cmd && !segment_pattern_cmd ##1
			!hex_digit_show_cmd && !segment_pattern_cmd
			|=> $stable(state_r.user_seg) && $stable(state_r.user_on);
	endproperty
	a_hold: assert property (p_hold) else $error("user content changed");

	// bad select raises fault and keeps content
	property p_bad_sel;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && !sel_ok
			|=> state_r.fault && $stable(state_r.user_seg) && $stable(state_r.user_on);
	endproperty
	a_bad_sel: assert property (p_bad_sel) else $error("bad select mishandled");

	// good select clears fault
	property p_good_sel;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && sel_ok |=> !state_r.fault;
	endproperty
	a_good_sel: assert property (p_good_sel) else $error("fault not cleared");

	// last command wins: a pattern after a digit command replaces it
	property p_last_wins;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !segment_pattern_cmd && sel_ok ##1 segment_pattern_cmd
			|=> state_r.user_seg == $past(pattern_word);
	endproperty
	a_last_wins: assert property (p_last_wins) else $error("older content shown");

	// error message overrides everything
	property p_err_first;
		@(posedge clk) disable iff (srst)
		sys_err_on |=> disp_src == SDD_SRC_ERROR && seg_out == $past(sys_err_seg);
	endproperty
	a_err_first: assert property (p_err_first) else $error("error not on top");

	// analog shows only without error or user content
	property p_analog;
		@(posedge clk) disable iff (srst)
		analog_on && !sys_err_on && !user_on_new |=> disp_src == SDD_SRC_ANALOG;
	endproperty
	a_analog: assert property (p_analog) else $error("analog priority wrong");

	// user content comes back after the error ends
	property p_restore;
		@(posedge clk) disable iff (srst)
		sys_err_on ##1 !sys_err_on && state_r.user_on && !hex_digit_show_cmd
			&& !segment_pattern_cmd |=> seg_out == state_r.user_seg
			&& disp_src == SDD_SRC_USER;
	endproperty
	a_restore: assert property (p_restore) else $error("user content lost");

	// pattern bits reach segments one to one
	property p_pattern;
		@(posedge clk) disable iff (srst)
		segment_pattern_cmd && pattern_word != SDD_SEG_BLANK && !sys_err_on
			|=> seg_out == $past(pattern_word);
	endproperty
	a_pattern: assert property (p_pattern) else $error("pattern not shown");

	// zero pattern blanks user display
	property p_zero;
		@(posedge clk) disable iff (srst)
		segment_pattern_cmd && pattern_word == SDD_SEG_BLANK |=> !state_r.user_on;
	endproperty
	a_zero: assert property (p_zero) else $error("zero pattern kept content");

	// pattern command keeps the fault flag
	property p_flag_kept;
		@(posedge clk) disable iff (srst)
		segment_pattern_cmd |=> $stable(fault_flag);
	endproperty
	a_flag_kept: assert property (p_flag_kept) else $error("fault touched by pattern");

	// user content beats analog and memory displays
	property p_user_over;
		@(posedge clk) disable iff (srst)
		user_on_new && !sys_err_on
			|=> disp_src == SDD_SRC_USER && seg_out == $past(user_seg_new);
	endproperty
	a_user_over: assert property (p_user_over) else $error("user rank wrong");

	// memory display shows only when nothing ranks above it
	property p_memory_last;
		@(posedge clk) disable iff (srst)
		memory_on && !analog_on && !sys_err_on && !user_on_new
			|=> disp_src == SDD_SRC_MEMORY && seg_out == $past(memory_seg);
	endproperty
	a_memory_last: assert property (p_memory_last) else $error("memory rank wrong");

	// main scenarios
	property p_cov_hex;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && sel_ok ##1 !hex_digit_show_cmd [*3];
	endproperty
	c_cov_hex: cover property (p_cov_hex);

	property p_cov_err_restore;
		@(posedge clk) disable iff (srst)
		state_r.user_on && sys_err_on ##1 !sys_err_on;
	endproperty
	c_cov_err_restore: cover property (p_cov_err_restore);

	property p_cov_bad_sel;
		@(posedge clk) disable iff (srst)
		hex_digit_show_cmd && !sel_ok;
	endproperty
	c_cov_bad_sel: cover property (p_cov_bad_sel);

	property p_cov_clear;
		@(posedge clk) disable iff (srst)
		state_r.user_on ##1 segment_pattern_cmd && pattern_word == SDD_SEG_BLANK;
	endproperty
	c_cov_clear: cover property (p_cov_clear);

	// memory display on with no error and no stored user content, analog not excluded
	property p_cov_low_src;
		@(posedge clk) disable iff (srst)
		!state_r.user_on && memory_on && !sys_err_on;
	endproperty
	c_cov_low_src: cover property (p_cov_low_src);

endmodule : sdd_ctrl

// ---- tb/sdd_cpu_model.sv ----
// command issuer model standing in for the instruction executor
`timescale 1ns/1ps
module sdd_cpu_model (
	// clock
	input wire logic clk,
	// digit command
	output logic hex_digit_show_cmd,
	output logic [15:0] src_word,
	output logic [15:0] sel_word,
	// pattern command
	output logic segment_pattern_cmd,
	output logic [15:0] pattern_word
);
	// idle at time zero
	initial begin
		hex_digit_show_cmd = 1'b0;
		segment_pattern_cmd = 1'b0;
		src_word = 16'h0000;
		sel_word = 16'h0000;
		pattern_word = 16'h0000;
	end
	// one execution per call, launched on the rising edge only
	task automatic issue(input logic hx, input logic sp, input logic [15:0] s,
		input logic [15:0] c, input logic [15:0] p);
		@(posedge clk);
		hex_digit_show_cmd <= hx;
		segment_pattern_cmd <= sp;
		// words with no strobe carry flipped garbage, never the last value
		src_word <= hx ? s : ~src_word;
		sel_word <= hx ? c : ~sel_word;
		pattern_word <= sp ? p : ~pattern_word;
	endtask : issue
endmodule : sdd_cpu_model

// ---- tb/tb.sv ----
// self-checking bench for the segment display controller
`timescale 1ns/1ps
module tb;
	import sdd_pkg::*;
	// clock, reset, system sources
	logic clk;
	logic srst;
	logic sys_err_on, analog_on, memory_on;
	logic [15:0] sys_err_seg, analog_seg, memory_seg;
	// command lines from the issuer model
	logic hx_w, sp_w;
	logic [15:0] src_w, sel_w, pat_w;
	// design outputs
	logic [15:0] seg_out;
	sdd_src_type disp_src;
	logic fault_flag, user_display_on;
	// bookkeeping and reference state
	int error_cnt, n_tests, seed;
	logic [15:0] r;
	logic [6:0] font [16];
	logic [15:0] m_seg;
	logic m_on, m_fault;
	logic [20:0] exp_q [$];

	sdd_cpu_model u_cpu (.clk(clk), .hex_digit_show_cmd(hx_w), .src_word(src_w),
		.sel_word(sel_w), .segment_pattern_cmd(sp_w), .pattern_word(pat_w));
	sdd_ctrl uut (.clk(clk), .srst(srst), .hex_digit_show_cmd(hx_w), .src_word(src_w),
		.sel_word(sel_w), .segment_pattern_cmd(sp_w), .pattern_word(pat_w),
		.sys_err_on(sys_err_on), .sys_err_seg(sys_err_seg), .analog_on(analog_on),
		.analog_seg(analog_seg), .memory_on(memory_on), .memory_seg(memory_seg),
		.seg_out(seg_out), .disp_src(disp_src), .fault_flag(fault_flag),
		.user_display_on(user_display_on));

	// 50 MHz clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// compare one value and count it
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// verdict and end of run
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	// one cycle of stimulus plus the expected outcome after the next edge
	task automatic step(input logic hx, input logic sp, input logic [15:0] s,
		input logic [15:0] c, input logic [15:0] p, input logic [2:0] sys);
		logic [7:0] b;
		logic [15:0] eseg;
		sdd_src_type esrc;
		u_cpu.issue(hx, sp, s, c, p);
		{sys_err_on, analog_on, memory_on} <= sys;
		b = (c == SDD_SEL_UPPER) ? s[15:8] : s[7:0];
		if (sp) begin
			m_seg = p;
			m_on = (p != SDD_SEG_BLANK);
		end else if (hx && (c == SDD_SEL_UPPER || c == SDD_SEL_LOWER)) begin
			m_seg = {1'b0, font[b[7:4]], 1'b0, font[b[3:0]]};
			m_on = 1'b1;
			m_fault = 1'b0;
		end else if (hx) begin
			m_fault = 1'b1;
		end
		// fixed priority of sources
		if (sys[2]) begin
			eseg = sys_err_seg;
			esrc = SDD_SRC_ERROR;
		end else if (m_on) begin
			eseg = m_seg;
			esrc = SDD_SRC_USER;
		end else if (sys[1]) begin
			eseg = analog_seg;
			esrc = SDD_SRC_ANALOG;
		end else if (sys[0]) begin
			eseg = memory_seg;
			esrc = SDD_SRC_MEMORY;
		end else begin
			eseg = SDD_SEG_BLANK;
			esrc = SDD_SRC_NONE;
		end
		@(negedge clk);
		exp_q.push_back({eseg, esrc, m_fault, m_on});
	endtask : step

	// watcher: settled outputs against the oldest note
	always @(posedge clk) begin : mon
		logic [20:0] e;
		#1;
		if (exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check("seg_out", seg_out, e[20:5]);
			check("disp_src", {13'h0000, disp_src}, {13'h0000, e[4:2]});
			check("fault_flag", {15'h0000, fault_flag}, {15'h0000, e[1]});
			check("user_on", {15'h0000, user_display_on}, {15'h0000, e[0]});
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		$display("watchdog expired");
		tally_and_finish();
	end

	// main sequence
	initial begin
		font = '{SDD_GLYPH_0, SDD_GLYPH_1, SDD_GLYPH_2, SDD_GLYPH_3, SDD_GLYPH_4,
			SDD_GLYPH_5, SDD_GLYPH_6, SDD_GLYPH_7, SDD_GLYPH_8, SDD_GLYPH_9,
			SDD_GLYPH_A, SDD_GLYPH_B, SDD_GLYPH_C, SDD_GLYPH_D, SDD_GLYPH_E, SDD_GLYPH_F};
		seed = 39;
		error_cnt = 0;
		n_tests = 0;
		m_seg = SDD_SEG_BLANK;
		m_on = 1'b0;
		m_fault = 1'b0;
		srst = 1'b1;
		{sys_err_on, analog_on, memory_on} = 3'b000;
		sys_err_seg = 16'($random(seed));
		analog_seg = 16'($random(seed));
		memory_seg = 16'($random(seed));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		#1;
		check("rst seg", seg_out, SDD_SEG_BLANK);
		check("rst flags", {11'h000, disp_src, fault_flag, user_display_on}, 16'h0000);
		// every byte once, even bytes through the upper select, odd bytes through the lower
		for (int i = 0; i < 256; i++) begin
			r = 16'($random(seed));
			step(1'b1, 1'b0, i[0] ? {r[7:0], i[7:0]} : {i[7:0], r[7:0]}, {15'h0000, i[0]},
				16'h0000, 3'b000);
		end
		$display("test font sweep done");
		// bad selects, hold, pattern keeps fault, valid clears it
		for (int k = 0; k < 4; k++) begin
			r = 16'($random(seed));
			step(1'b1, 1'b0, r, (k == 3) ? (r | 16'h0002) : (16'h0002 << (k * 7)), 16'h0000,
				3'b000);
			step(1'b0, 1'b0, r, 16'h0000, 16'h0000, 3'b000);
			step(1'b0, 1'b1, 16'h0000, 16'h0000, r | 16'h0001, 3'b000);
			step(1'b0, 1'b0, r, 16'h0000, 16'h0000, 3'b000);
		end
		step(1'b1, 1'b0, 16'h12AC, SDD_SEL_LOWER, 16'h0000, 3'b000);
		$display("test fault and hold done");
		// back-to-back mixed commands, repeats, both strobes at once
		for (int i = 0; i < 30; i++) begin
			r = 16'($random(seed));
			step(i % 3 != 0, i % 3 != 1, r, {15'h0000, r[3]}, ~r, 3'b000);
			if (i % 5 == 0) begin
				step(i % 3 != 0, i % 3 != 1, r, {15'h0000, r[3]}, ~r, 3'b000);
			end
		end
		$display("test mixed commands done");
		// error overrides then restores user content
		step(1'b1, 1'b0, 16'hAC00, SDD_SEL_UPPER, 16'h0000, 3'b000);
		step(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 3'b100);
		step(1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 3'b011);
		// every source mix, user cleared midway by a blank pattern
		for (int i = 0; i < 16; i++) begin
			step(1'b0, i == 8, 16'h0000, 16'h0000, 16'h0000, i[2:0]);
		end
		$display("test priority done");
		repeat (3) @(posedge clk);
		tally_and_finish();
	end
endmodule : tb
